// file: verilog/ucps_pkg.sv
// Shared constants and carrier types for the UART channel pin signalling
package ucps_pkg;

    // Channel count and FIFO sizing
    localparam int NUM_CHAN = 2;
    localparam int FIFO_DEPTH = 64;
    localparam int LVL_W = 7;

    // Register byte offsets within one channel window
    localparam logic [7:0] OFF_MCR = 8'h00;
    localparam logic [7:0] OFF_IER = 8'h04;
    localparam logic [7:0] OFF_EFR = 8'h08;
    localparam logic [7:0] OFF_MSR = 8'h0C;
    localparam logic [7:0] OFF_RXTRIG = 8'h10;
    localparam logic [7:0] OFF_TXTRIG = 8'h14;
    // Channel B window starts here; address bit 5 picks the channel
    localparam logic [7:0] CHAN_STRIDE = 8'h20;
    localparam int CHAN_SEL_BIT = 5;

    // Field positions
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_IRQEN_BIT = 3;
    localparam int MCR_LOOP_BIT = 4;
    localparam int IER_MS_BIT = 3;
    localparam int EFR_ARTS_BIT = 6;
    localparam int MSR_RI_EDGE_BIT = 2;
    localparam int MSR_RI_LVL_BIT = 6;

    // Reset values
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [7:0] RXTRIG_RST = 8'h08;
    localparam logic [7:0] TXTRIG_RST = 8'h08;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Configuration handed to one channel
    typedef struct packed {
        logic rts_req;
        logic irq_en;
        logic loopback;
        logic ms_ie;
        logic auto_rts;
        logic [LVL_W-1:0] rx_trig;
        logic [LVL_W-1:0] tx_trig;
    } ucps_cfg_t;

    // FIFO status from the rest of the channel
    typedef struct packed {
        logic [LVL_W-1:0] rx_level;
        logic rx_timeout;
        logic rx_error;
        logic [LVL_W-1:0] tx_free;
        logic tx_full;
    } ucps_fifo_t;

    // Whole state of one channel
    typedef struct packed {
        logic ri_s1;
        logic ri_s2;
        logic ri_prev;
        logic ri_flag;
        logic rts_n;
        logic ser_out;
        logic rx_to_rcv;
        logic rxrdy_n;
        logic txrdy_n;
        logic irq;
        logic hold;
    } ucps_chan_st_t;

    // Pins idle high, flags clear
    localparam ucps_chan_st_t CHAN_RST = '{ri_s1: 1'b1, ri_s2: 1'b1,
        ri_prev: 1'b1, ri_flag: 1'b0, rts_n: 1'b1, ser_out: 1'b1,
        rx_to_rcv: 1'b1, rxrdy_n: 1'b1, txrdy_n: 1'b1, irq: 1'b0,
        hold: 1'b0};

    // Bus phases
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_RESP = 1'b1
    } ucps_phase_t;

endpackage

// file: verilog/ucps_chan.sv
// One UART channel: ring input, ready outputs, loopback gating, interrupt
`timescale 1ns/10ps
module ucps_chan (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control from registers
    input wire ucps_pkg::ucps_cfg_t cfg,
    input wire logic msr_rd,
    input wire logic irq_other,
    // FIFO and transmitter side
    input wire ucps_pkg::ucps_fifo_t fifo,
    input wire logic tx_data,
    // Pins
    input wire logic ring_n,
    input wire logic serial_in,
    output logic rts_n,
    output logic serial_out,
    output logic rxrdy_n,
    output logic txrdy_n,
    output logic irq,
    // Internal results
    output logic rx_to_rcv,
    output logic hold,
    output logic ri_level,
    output logic ri_flag
);
    import ucps_pkg::*;

    ucps_chan_st_t q;
    ucps_chan_st_t d;
    logic ri_rise;

    // Next state of the whole channel
    always_comb begin
        d = q;
        d.ri_s1 = ring_n;
        d.ri_s2 = q.ri_s1;
        d.ri_prev = q.ri_s2;
        ri_rise = q.ri_s2 & ~q.ri_prev;
        if (msr_rd) begin
            d.ri_flag = 1'b0;
        end
        // A new edge beats a status read in the same cycle
        if (ri_rise) begin
            d.ri_flag = 1'b1;
        end
        // control bit drives the pin low
        d.rts_n = ~cfg.rts_req;
        // flow gating only with auto mode
        d.hold = cfg.auto_rts & q.rts_n;
        if (cfg.loopback) begin
            d.ser_out = 1'b1;
            d.rx_to_rcv = tx_data;
        end else begin
            d.ser_out = tx_data;
            d.rx_to_rcv = serial_in;
        end
        if (fifo.rx_level >= cfg.rx_trig || fifo.rx_timeout) begin
            d.rxrdy_n = 1'b0;
        end
        if (fifo.rx_level == '0 || fifo.rx_error) begin
            d.rxrdy_n = 1'b1;
        end
        if (fifo.tx_free >= cfg.tx_trig) begin
            d.txrdy_n = 1'b0;
        end
        if (fifo.tx_full) begin
            d.txrdy_n = 1'b1;
        end
        d.irq = cfg.irq_en & ((q.ri_flag & cfg.ms_ie) | irq_other);
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= CHAN_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops, ri_level through an inverter
    assign rts_n = q.rts_n;
    assign serial_out = q.ser_out;
    assign rxrdy_n = q.rxrdy_n;
    assign txrdy_n = q.txrdy_n;
    assign irq = q.irq;
    assign rx_to_rcv = q.rx_to_rcv;
    assign hold = q.hold;
    assign ri_level = ~q.ri_s2;
    assign ri_flag = q.ri_flag;

endmodule

// file: verilog/ucps_top.sv
// Two-channel UART pin signalling with an AXI4-Lite register slave
// Summary of operation
// - Each channel owns its full set of pins.
// - Ring rising edge raises enabled modem interrupt.
// - Ring level readable in modem status register.
// - Control bit one drives request-to-send low.
// - Request-to-send held high after reset.
// - Request-to-send gates flow only in auto mode.
// - Loopback ignores receive pin, loops transmit data.
// - Loopback disconnects the transmit pin.
// - Receive ready low at trigger or timeout.
// - Receive ready high when empty or error.
// - Transmit ready low with trigger free spaces.
// - Transmit ready high when buffer full.
// - Interrupt output needs control enable bit.
`timescale 1ns/10ps
module ucps_top #(
    parameter int ADDR_W = 8,
    parameter int DEPTH = ucps_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Channel A pins
    input wire logic ring_indicator_in_a,
    input wire logic serial_in_a,
    output logic request_to_send_out_a,
    output logic serial_out_a,
    output logic receive_ready_out_a,
    output logic transmit_ready_out_a,
    output logic irq_out_a,
    // Channel B pins
    input wire logic ring_indicator_in_b,
    input wire logic serial_in_b,
    output logic request_to_send_out_b,
    output logic serial_out_b,
    output logic receive_ready_out_b,
    output logic transmit_ready_out_b,
    output logic irq_out_b,
    // Channel A core side
    input wire ucps_pkg::ucps_fifo_t fifo_a,
    input wire logic tx_data_a,
    input wire logic irq_other_a,
    output logic rx_to_rcv_a,
    output logic flow_hold_a,
    // Channel B core side
    input wire ucps_pkg::ucps_fifo_t fifo_b,
    input wire logic tx_data_b,
    input wire logic irq_other_b,
    output logic rx_to_rcv_b,
    output logic flow_hold_b
);
    import ucps_pkg::*;

    // Trigger fields only reach the FIFO's own count range
    if (ADDR_W < 8 || DEPTH > FIFO_DEPTH || DEPTH < 1) begin : g_bad_param
        $error("ucps_top: unsupported ADDR_W or DEPTH");
    end

    // Whole bus and register state
    typedef struct packed {
        ucps_phase_t wph;
        ucps_phase_t rph;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0][7:0] modem_control_reg;
        logic [1:0][7:0] interrupt_enable_reg;
        logic [1:0][7:0] enhanced_feature_reg;
        logic [1:0][7:0] rxt;
        logic [1:0][7:0] txt;
    } ucps_top_st_t;

    ucps_top_st_t q;
    ucps_top_st_t d;

    ucps_cfg_t [1:0] cfg;
    logic [1:0] msr_rd;
    logic [1:0] ri_level;
    logic [1:0] ri_flag;
    logic [1:0] ring_n;
    logic [1:0] ser_in;
    logic [1:0] rts_n;
    logic [1:0] ser_out;
    logic [1:0] rxrdy_n;
    logic [1:0] txrdy_n;
    logic [1:0] irq;
    logic [1:0] rx_rcv;
    logic [1:0] hold;
    logic [1:0] tx_data;
    logic [1:0] irq_other;
    ucps_fifo_t [1:0] fifo;

    // Offset within a channel window, or all ones if unmapped
    function automatic logic [7:0] reg_off(input logic [7:0] a);
        logic [7:0] o;
        o = a & ~CHAN_STRIDE;
        if (o == OFF_MCR || o == OFF_IER || o == OFF_EFR ||
            o == OFF_MSR || o == OFF_RXTRIG || o == OFF_TXTRIG) begin
            return o;
        end
        return 8'hFF;
    endfunction

    logic [7:0] raddr;
    logic [7:0] woff;
    logic [7:0] roff;
    logic wch;
    logic rch;
    logic [7:0] rval;
    logic [7:0] msr_val;

    // Bus decode and register update
    always_comb begin
        d = q;
        msr_rd = 2'h0;
        raddr = s_axi_araddr[7:0];
        woff = reg_off(q.awaddr);
        wch = q.awaddr[CHAN_SEL_BIT];
        roff = reg_off(raddr);
        rch = raddr[CHAN_SEL_BIT];
        msr_val = 8'h00;
        msr_val[MSR_RI_LVL_BIT] = ri_level[rch];
        msr_val[MSR_RI_EDGE_BIT] = ri_flag[rch];
        // Capture write address and data in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        // Write once both halves are held
        if (q.wph == PH_IDLE && q.aw_got && q.w_got) begin
            d.wph = PH_RESP;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bresp = (woff == 8'hFF || woff == OFF_MSR ||
                       q.awaddr[7:6] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            if (q.wstrb0 && q.awaddr[7:6] == 2'h0) begin
                case (woff)
                    OFF_MCR: d.modem_control_reg[wch] = q.wdata;
                    OFF_IER: d.interrupt_enable_reg[wch] = q.wdata;
                    OFF_EFR: d.enhanced_feature_reg[wch] = q.wdata;
                    OFF_RXTRIG: d.rxt[wch] = q.wdata;
                    OFF_TXTRIG: d.txt[wch] = q.wdata;
                    default: d.bresp = d.bresp;
                endcase
            end
        end else if (q.wph == PH_RESP && s_axi_bready) begin
            d.wph = PH_IDLE;
        end
        d.awready = ~d.aw_got && d.wph == PH_IDLE;
        d.wready = ~d.w_got && d.wph == PH_IDLE;
        // Reads answer one cycle after the address is taken
        case (roff)
            OFF_MCR: rval = q.modem_control_reg[rch];
            OFF_IER: rval = q.interrupt_enable_reg[rch];
            OFF_EFR: rval = q.enhanced_feature_reg[rch];
            // live ring level and edge flag
            OFF_MSR: rval = msr_val;
            OFF_RXTRIG: rval = q.rxt[rch];
            OFF_TXTRIG: rval = q.txt[rch];
            default: rval = 8'h00;
        endcase
        if (s_axi_arvalid && q.arready) begin
            d.rph = PH_RESP;
            d.rdata = {24'h000000, rval};
            d.rresp = (roff == 8'hFF || raddr[7:6] != 2'h0) ?
                      RESP_SLVERR : RESP_OKAY;
            // Reading status clears the sticky ring flag
            if (roff == OFF_MSR && raddr[7:6] == 2'h0) begin
                msr_rd[rch] = 1'b1;
            end
        end else if (q.rph == PH_RESP && s_axi_rready) begin
            d.rph = PH_IDLE;
        end
        d.arready = d.rph == PH_IDLE;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{wph: PH_IDLE, rph: PH_IDLE, aw_got: 1'b0, w_got: 1'b0,
                   awaddr: 8'h00, wdata: 8'h00, wstrb0: 1'b0,
                   awready: 1'b1, wready: 1'b1, bresp: RESP_OKAY,
                   arready: 1'b1, rdata: 32'h00000000, rresp: RESP_OKAY,
                   modem_control_reg: {MCR_RST, MCR_RST}, interrupt_enable_reg: {IER_RST, IER_RST},
                   enhanced_feature_reg: {EFR_RST, EFR_RST},
                   rxt: {RXTRIG_RST, RXTRIG_RST},
                   txt: {TXTRIG_RST, TXTRIG_RST}};
        end else begin
            q <= d;
        end
    end

    // Bus outputs from flops
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.wph == PH_RESP;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rph == PH_RESP;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // Gather per-channel pins into vectors
    assign ring_n = {ring_indicator_in_b, ring_indicator_in_a};
    assign ser_in = {serial_in_b, serial_in_a};
    assign tx_data = {tx_data_b, tx_data_a};
    assign irq_other = {irq_other_b, irq_other_a};
    assign fifo = {fifo_b, fifo_a};

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        assign cfg[c] = '{rts_req: q.modem_control_reg[c][MCR_RTS_BIT],
                          irq_en: q.modem_control_reg[c][MCR_IRQEN_BIT],
                          loopback: q.modem_control_reg[c][MCR_LOOP_BIT],
                          ms_ie: q.interrupt_enable_reg[c][IER_MS_BIT],
                          auto_rts: q.enhanced_feature_reg[c][EFR_ARTS_BIT],
                          rx_trig: q.rxt[c][LVL_W-1:0],
                          tx_trig: q.txt[c][LVL_W-1:0]};
        ucps_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cfg[c]),
            .msr_rd(msr_rd[c]),
            .irq_other(irq_other[c]),
            .fifo(fifo[c]),
            .tx_data(tx_data[c]),
            .ring_n(ring_n[c]),
            .serial_in(ser_in[c]),
            .rts_n(rts_n[c]),
            .serial_out(ser_out[c]),
            .rxrdy_n(rxrdy_n[c]),
            .txrdy_n(txrdy_n[c]),
            .irq(irq[c]),
            .rx_to_rcv(rx_rcv[c]),
            .hold(hold[c]),
            .ri_level(ri_level[c]),
            .ri_flag(ri_flag[c])
        );
    end

    // Pin outputs, each a channel flop
    assign request_to_send_out_a = rts_n[0];
    assign request_to_send_out_b = rts_n[1];
    assign serial_out_a = ser_out[0];
    assign serial_out_b = ser_out[1];
    assign receive_ready_out_a = rxrdy_n[0];
    assign receive_ready_out_b = rxrdy_n[1];
    assign transmit_ready_out_a = txrdy_n[0];
    assign transmit_ready_out_b = txrdy_n[1];
    assign irq_out_a = irq[0];
    assign irq_out_b = irq[1];
    assign rx_to_rcv_a = rx_rcv[0];
    assign rx_to_rcv_b = rx_rcv[1];
    assign flow_hold_a = hold[0];
    assign flow_hold_b = hold[1];

    // Checks on channel A, the reset check also on B; mirrored behaviour holds for B
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_rts_reset;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> request_to_send_out_a && request_to_send_out_b;
    endproperty
    a_rts_reset: assert property (p_rts_reset)
        else $error("rts not high after reset");

    property p_rts_follow;
        $changed(q.modem_control_reg[0][MCR_RTS_BIT]) |=>
            request_to_send_out_a == !$past(q.modem_control_reg[0][MCR_RTS_BIT]);
    endproperty
    a_rts_follow: assert property (p_rts_follow)
        else $error("rts does not follow control bit");

    sequence s_ring_rise;
        !ring_indicator_in_a ##1 ring_indicator_in_a [*3];
    endsequence
    property p_ri_event;
        s_ring_rise |=> ri_flag[0];
    endproperty
    a_ri_event: assert property (p_ri_event)
        else $error("ring edge not flagged");

    property p_ri_level;
        ri_level[0] == !$past(ring_indicator_in_a, 2);
    endproperty
    a_ri_level: assert property (p_ri_level)
        else $error("status ring level wrong");

    property p_ri_single;
        $rose(ri_flag[0]) |-> $past(ri_level[0], 2) && !$past(ri_level[0]);
    endproperty
    a_ri_single: assert property (p_ri_single)
        else $error("ring flag without synchronised edge");

    property p_arts;
        flow_hold_a |-> $past(q.enhanced_feature_reg[0][EFR_ARTS_BIT]);
    endproperty
    a_arts: assert property (p_arts)
        else $error("flow hold without auto mode");

    property p_loop_rx;
        q.modem_control_reg[0][MCR_LOOP_BIT] |=> rx_to_rcv_a == $past(tx_data_a);
    endproperty
    a_loop_rx: assert property (p_loop_rx)
        else $error("loopback receive path wrong");

    property p_loop_tx;
        q.modem_control_reg[0][MCR_LOOP_BIT] |=> serial_out_a;
    endproperty
    a_loop_tx: assert property (p_loop_tx)
        else $error("transmit pin not idle in loopback");

    property p_rxrdy_low;
        (fifo_a.rx_timeout || fifo_a.rx_level >= q.rxt[0][LVL_W-1:0]) &&
        fifo_a.rx_level != '0 && !fifo_a.rx_error |=> !receive_ready_out_a;
    endproperty
    a_rxrdy_low: assert property (p_rxrdy_low)
        else $error("receive ready not asserted");

    property p_rxrdy_high;
        fifo_a.rx_level == '0 || fifo_a.rx_error |=> receive_ready_out_a;
    endproperty
    a_rxrdy_high: assert property (p_rxrdy_high)
        else $error("receive ready not released");

    property p_txrdy_low;
        !fifo_a.tx_full && fifo_a.tx_free >= q.txt[0][LVL_W-1:0]
            |=> !transmit_ready_out_a;
    endproperty
    a_txrdy_low: assert property (p_txrdy_low)
        else $error("transmit ready not asserted");

    property p_txrdy_high;
        fifo_a.tx_full |=> transmit_ready_out_a;
    endproperty
    a_txrdy_high: assert property (p_txrdy_high)
        else $error("transmit ready low while full");

    property p_irq_gate;
        irq_out_a |-> $past(q.modem_control_reg[0][MCR_IRQEN_BIT]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable bit");

    // Main scenarios
    c_ring_irq: cover property (s_ring_rise ##[1:4] irq_out_a);
    c_loopback: cover property (q.modem_control_reg[0][MCR_LOOP_BIT] ##1 !rx_to_rcv_a);
    c_rxrdy: cover property (!receive_ready_out_a ##[1:20]
                             receive_ready_out_a);

endmodule

// file: verification/ucps_far_model.sv
// Remote modem and serial party model facing one channel's pins
`timescale 1ns/10ps
module ucps_far_model (
    // Clock
    input wire logic aclk,
    // Commands from the bench
    input wire logic ring_on,
    input wire logic send_en,
    input wire logic send_bit,
    // Pins toward the device
    output logic ring_n,
    output logic serial_in
);
    // Pins start idle so the device never sees an unknown level
    initial begin
        ring_n = 1'b1;
        serial_in = 1'b1;
    end
    // Ring pin is active low; changes land just after the edge
    // idle line high
    always @(posedge aclk) begin
        ring_n <= !ring_on;
        serial_in <= send_en ? send_bit : 1'b1;
    end
endmodule

// file: verification/tb.sv
// Self-checking bench for the two-channel pin signalling block
`timescale 1ns/10ps
module tb;
    import ucps_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, arready, bvalid, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic rts_a, rts_b, sout_a, rxr_a, txr_a, irq_a, rcv_a, hold_a;
    logic ring_on = 1'b0, send_en = 1'b0, send_bit = 1'b1;
    logic ring_a, sin_a, tx_a = 1'b1, oth_a = 1'b0;
    ucps_fifo_t fifo_a = '0;
    int n_mismatch = 0, checked = 0;
    logic [7:0] base;
    logic bready = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'h1;
    logic [5:0] pb;

    // Free-running 25 MHz clock
    always #20 aclk = ~aclk;

    ucps_far_model u_far (.aclk(aclk), .ring_on(ring_on),
        .send_en(send_en), .send_bit(send_bit), .ring_n(ring_a),
        .serial_in(sin_a));

    // Channel B pins and core side are held idle
    ucps_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .ring_indicator_in_a(ring_a), .serial_in_a(sin_a),
        .request_to_send_out_a(rts_a), .serial_out_a(sout_a),
        .receive_ready_out_a(rxr_a), .transmit_ready_out_a(txr_a),
        .irq_out_a(irq_a), .ring_indicator_in_b(1'b1),
        .serial_in_b(1'b1), .request_to_send_out_b(rts_b),
        .serial_out_b(pb[5]), .receive_ready_out_b(pb[4]),
        .transmit_ready_out_b(pb[3]), .irq_out_b(pb[2]), .fifo_a(fifo_a),
        .tx_data_a(tx_a), .irq_other_a(oth_a), .rx_to_rcv_a(rcv_a),
        .flow_hold_a(hold_a), .fifo_b('0), .tx_data_b(1'b1),
        .irq_other_b(1'b0), .rx_to_rcv_b(pb[1]), .flow_hold_b(pb[0]));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write; both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                got = 1'b1;
                bready <= 1'b0;
            end
        end
        check(bresp, er);
        check(got, 1'b1);
        // One idle edge so the next call never re-raises in this step
        @(posedge aclk);
    endtask

    // Read; rready rises with the request and drops once answered
    task automatic rdx(input logic [7:0] a);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                got = 1'b1;
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
        check(got, 1'b1);
        @(posedge aclk);
    endtask

    task automatic summarize();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Guards against a hung handshake
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end

    initial begin
        cyc(12);
        aresetn <= 1'b1;
        cyc(2);
        check({rts_a, rts_b, irq_a, rxr_a, txr_a}, 5'h1B);
        check(pb, 6'h3A);
        rdx(OFF_MCR); check(rd, {24'h0, MCR_RST});
        rdx(OFF_IER); check(rd, {24'h0, IER_RST});
        rdx(OFF_EFR); check(rd, {24'h0, EFR_RST});
        rdx(OFF_RXTRIG); check(rd, {24'h0, RXTRIG_RST});
        rdx(OFF_TXTRIG); check(rd, {24'h0, TXTRIG_RST});
        // A write with no byte lane enabled is accepted, changes nothing
        wstrb <= 4'h0;
        wr(OFF_RXTRIG, 32'h55, RESP_OKAY);
        wstrb <= 4'h1;
        rdx(OFF_RXTRIG); check(rd, {24'h0, RXTRIG_RST});
        // Unmapped and read-only places refuse with an error
        wr(8'h40, 32'hFF, RESP_SLVERR);
        rdx(8'h40); check({rs, rd}, {RESP_SLVERR, 32'h0});
        wr(OFF_MSR, 32'hFF, RESP_SLVERR);
        // each channel drives only its own line
        for (int c = 0; c < 2; c++) begin
            base = (c == 1) ? CHAN_STRIDE : 8'h00;
            wr(base + OFF_MCR, 32'h02, RESP_OKAY); cyc(3);
            check({rts_a, rts_b}, (c == 1) ? 2'b10 : 2'b01);
            wr(base + OFF_MCR, 32'h00, RESP_OKAY); cyc(3);
            check({rts_a, rts_b}, 2'b11);
        end
        // hold only in auto mode with request deasserted
        wr(OFF_EFR, 32'h40, RESP_OKAY); cyc(3);
        check(hold_a, 1'b1);
        wr(OFF_MCR, 32'h02, RESP_OKAY); cyc(3);
        check(hold_a, 1'b0);
        wr(OFF_EFR, 32'h00, RESP_OKAY); wr(OFF_MCR, 32'h0, RESP_OKAY);
        cyc(3); check(hold_a, 1'b0);
        wr(OFF_MCR, 32'h08, RESP_OKAY); wr(OFF_IER, 32'h08, RESP_OKAY);
        ring_on <= 1'b1; cyc(6);
        rdx(OFF_MSR); check(rd & 32'h44, 32'h40);
        check(irq_a, 1'b0);
        ring_on <= 1'b0; cyc(8);
        check(irq_a, 1'b1);
        rdx(OFF_MSR); check(rd & 32'h44, 32'h04);
        cyc(3); check(irq_a, 1'b0);
        rdx(OFF_MSR); check(rd & 32'h44, 32'h00);
        // Other sources gated by the control enable bit
        wr(OFF_MCR, 32'h00, RESP_OKAY); oth_a <= 1'b1; cyc(3);
        check(irq_a, 1'b0);
        wr(OFF_MCR, 32'h08, RESP_OKAY); cyc(3);
        check(irq_a, 1'b1);
        oth_a <= 1'b0;
        // loopback ignores the pin and parks the output high
        wr(OFF_MCR, 32'h10, RESP_OKAY); tx_a <= 1'b0; cyc(3);
        check({sout_a, rcv_a}, 2'b10);
        tx_a <= 1'b1; send_en <= 1'b1; send_bit <= 1'b0; cyc(3);
        check({sout_a, rcv_a}, 2'b11);
        wr(OFF_MCR, 32'h00, RESP_OKAY); tx_a <= 1'b0; cyc(3);
        check({sout_a, rcv_a}, 2'b00);
        send_en <= 1'b0; cyc(3);
        check(rcv_a, 1'b1);
        // receive ready thresholds, hold band, error wins
        wr(OFF_RXTRIG, 32'h03, RESP_OKAY);
        fifo_a.rx_level <= 7'd3; cyc(3); check(rxr_a, 1'b0);
        fifo_a.rx_level <= 7'd1; cyc(3); check(rxr_a, 1'b0);
        fifo_a.rx_level <= 7'd0; cyc(3); check(rxr_a, 1'b1);
        fifo_a.rx_level <= 7'd1; cyc(3); check(rxr_a, 1'b1);
        fifo_a.rx_timeout <= 1'b1; cyc(3); check(rxr_a, 1'b0);
        fifo_a.rx_error <= 1'b1; cyc(3); check(rxr_a, 1'b1);
        // transmit ready at trigger free spaces, full releases it
        fifo_a.tx_free <= 7'd8; cyc(3); check(txr_a, 1'b0);
        fifo_a.tx_free <= 7'd7; cyc(3); check(txr_a, 1'b0);
        fifo_a.tx_full <= 1'b1; cyc(3); check(txr_a, 1'b1);
        fifo_a.tx_full <= 1'b0; cyc(3); check(txr_a, 1'b1);
        // Channel B pins untouched by all channel A activity
        check(pb, 6'h3A);
        summarize();
    end
endmodule
